// ### src/tctc_consts.svh
`ifndef TCTC_CONSTS_SVH
`define TCTC_CONSTS_SVH

// Register offsets
`define TCTC_ADDR_ENABLE   8'h21
`define TCTC_ADDR_TIMING   8'h22
`define TCTC_ADDR_HOLD     8'h23

// Reset values
`define TCTC_RST_ENABLE    8'hff
`define TCTC_RST_TIMING    8'ha4
`define TCTC_RST_HOLD      8'h07
`define TCTC_RDATA_NONE    8'h00

// Field positions
`define TCTC_MAXDUR_MSB    7
`define TCTC_MAXDUR_LSB    4
`define TCTC_RPT_MSB       3
`define TCTC_RPT_LSB       0
`define TCTC_HOLD_MSB      3
`define TCTC_HOLD_LSB      0

// Timing
`define TCTC_CLK_HZ        125000000
`define TCTC_MS_PER_S      1000
`define TCTC_STEP_MS       35
`define TCTC_CYCLE_MS      70
`define TCTC_DUR_SAT       14'h3fff

// Max touch time decode, ms
`define TCTC_MAXDUR_MS0    560
`define TCTC_MAXDUR_MS1    840
`define TCTC_MAXDUR_MS2    1120
`define TCTC_MAXDUR_MS3    1400
`define TCTC_MAXDUR_MS4    1680
`define TCTC_MAXDUR_MS5    2240
`define TCTC_MAXDUR_MS6    2800
`define TCTC_MAXDUR_MS7    3360
`define TCTC_MAXDUR_MS8    3920
`define TCTC_MAXDUR_MS9    4480
`define TCTC_MAXDUR_MS10   5600
`define TCTC_MAXDUR_MS11   6720
`define TCTC_MAXDUR_MS12   7840
`define TCTC_MAXDUR_MS13   8906
`define TCTC_MAXDUR_MS14   10080
`define TCTC_MAXDUR_MS15   11200

`endif

// ### src/tctc_pkg.sv
package tctc_pkg;
  typedef logic [13:0] tctc_ms_type;
  typedef logic [7:0]  tctc_byte_type;
  typedef logic [3:0]  tctc_code_type;
endpackage

// ### src/tctc_top.sv
`timescale 1ns/1ps
`include "tctc_consts.svh"
// Contract
// RULE1 - Eight enable bits, bit n for input n+1, set includes the input, all set after reset.
// RULE2 - The sampling cycle length stays fixed whatever number of inputs is enabled.
// RULE3 - The three timing settings are shared by all eight inputs.
// RULE4 - The max touch time field is the upper nibble of the timing register, reset 1010b.
// RULE5 - Max touch codes 0 to 15 decode to 560 through 11200 ms per the fixed table.
// RULE6 - A touch held past the max time forces recalibration only when the global enable is set.
// RULE7 - The repeat interval field is the lower nibble of the timing register, reset 0100b.
// RULE8 - The repeat interval is (code+1) times 35 ms.
// RULE9 - An interrupt fires on press and each repeat interval, and on release unless suppressed.
// RULE10 - The hold threshold is the low nibble of the second timing register, reset 0111b.
// RULE11 - An auto-repeat touch longer than the threshold is press-and-hold, otherwise a touch.
// RULE12 - The hold threshold is (code+1) times 35 ms.
// RULE13 - Per-input duration and repeat timers restart on release or when the input is disabled.
module tctc_top #(
  parameter int TICK_CYCLES = `TCTC_CLK_HZ / `TCTC_MS_PER_S,
  parameter int CHANNELS    = 8
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_wr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_rd,
  output logic [7:0]               reg_rdata,
  input  wire logic [CHANNELS-1:0] touch_raw,
  input  wire logic [CHANNELS-1:0] auto_repeat_en,
  input  wire logic                max_touch_recal_en,
  input  wire logic                release_irq_suppress,
  output logic [CHANNELS-1:0]      sample_en,
  output logic                     cycle_start,
  output logic [CHANNELS-1:0]      touch_detected,
  output logic [CHANNELS-1:0]      recal_req,
  output logic [CHANNELS-1:0]      hold_event,
  output logic [CHANNELS-1:0]      touch_event,
  output logic                     irq_req
);

  ////////////////////////////////////////////////////////////////////
  // Decode functions
  function automatic tctc_pkg::tctc_ms_type max_ms(input tctc_pkg::tctc_code_type code);
    unique case (code)
      4'h0: max_ms = 14'(`TCTC_MAXDUR_MS0);
      4'h1: max_ms = 14'(`TCTC_MAXDUR_MS1);
      4'h2: max_ms = 14'(`TCTC_MAXDUR_MS2);
      4'h3: max_ms = 14'(`TCTC_MAXDUR_MS3);
      4'h4: max_ms = 14'(`TCTC_MAXDUR_MS4);
      4'h5: max_ms = 14'(`TCTC_MAXDUR_MS5);
      4'h6: max_ms = 14'(`TCTC_MAXDUR_MS6);
      4'h7: max_ms = 14'(`TCTC_MAXDUR_MS7);
      4'h8: max_ms = 14'(`TCTC_MAXDUR_MS8);
      4'h9: max_ms = 14'(`TCTC_MAXDUR_MS9);
      4'ha: max_ms = 14'(`TCTC_MAXDUR_MS10);
      4'hb: max_ms = 14'(`TCTC_MAXDUR_MS11);
      4'hc: max_ms = 14'(`TCTC_MAXDUR_MS12);
      4'hd: max_ms = 14'(`TCTC_MAXDUR_MS13);
      4'he: max_ms = 14'(`TCTC_MAXDUR_MS14);
      4'hf: max_ms = 14'(`TCTC_MAXDUR_MS15);
    endcase
  endfunction

  function automatic tctc_pkg::tctc_ms_type step_ms(input tctc_pkg::tctc_code_type code);
    step_ms = 14'((32'(code) + 1) * `TCTC_STEP_MS);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Registers
  tctc_pkg::tctc_byte_type channel_sample_enable;
  tctc_pkg::tctc_byte_type touch_timing_config;
  tctc_pkg::tctc_byte_type hold_threshold_config;
  tctc_pkg::tctc_byte_type next_rdata;

  wire sel_enable = reg_addr == `TCTC_ADDR_ENABLE;
  wire sel_timing = reg_addr == `TCTC_ADDR_TIMING;
  wire sel_hold   = reg_addr == `TCTC_ADDR_HOLD;

  // RULE10 upper bits read zero
  assign next_rdata = sel_enable ? channel_sample_enable :
                      sel_timing ? touch_timing_config :
                      sel_hold   ? {4'h0, hold_threshold_config[`TCTC_HOLD_MSB:`TCTC_HOLD_LSB]} :
                                   `TCTC_RDATA_NONE;

  // RULE1 enable reset all set
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      channel_sample_enable <= `TCTC_RST_ENABLE;
      touch_timing_config   <= `TCTC_RST_TIMING;
      hold_threshold_config <= `TCTC_RST_HOLD;
      reg_rdata             <= `TCTC_RDATA_NONE;
    end else begin
      if (reg_wr && sel_enable) begin
        channel_sample_enable <= reg_wdata;
      end
      // RULE4 RULE7 timing register write
      if (reg_wr && sel_timing) begin
        touch_timing_config <= reg_wdata;
      end
      // RULE10 low nibble only
      if (reg_wr && sel_hold) begin
        hold_threshold_config <= {4'h0, reg_wdata[`TCTC_HOLD_MSB:`TCTC_HOLD_LSB]};
      end
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Millisecond tick and fixed sampling cycle
  logic [16:0] tick_cnt;
  logic [7:0]  cycle_cnt;
  wire         tick       = tick_cnt == 17'(TICK_CYCLES - 1);
  wire         cycle_wrap = tick && (cycle_cnt == 8'(`TCTC_CYCLE_MS - 1));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt    <= 17'h0_0000;
      cycle_cnt   <= 8'h00;
      cycle_start <= 1'b0;
    end else begin
      tick_cnt <= tick ? 17'h0_0000 : tick_cnt + 17'h0_0001;
      // RULE2 cycle ignores enables
      if (tick) begin
        cycle_cnt <= cycle_wrap ? 8'h00 : cycle_cnt + 8'h01;
      end
      cycle_start <= cycle_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Touch input synchroniser
  logic [CHANNELS-1:0] touch_meta;
  logic [CHANNELS-1:0] touch_sync;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      touch_meta <= '0;
      touch_sync <= '0;
    end else begin
      touch_meta <= touch_raw;
      touch_sync <= touch_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Per-channel timing
  // RULE3 shared timing settings
  tctc_pkg::tctc_ms_type limit_max;
  tctc_pkg::tctc_ms_type limit_rpt;
  tctc_pkg::tctc_ms_type limit_hold;
  // RULE5 max time decode
  assign limit_max  = max_ms(touch_timing_config[`TCTC_MAXDUR_MSB:`TCTC_MAXDUR_LSB]);
  // RULE8 repeat decode
  assign limit_rpt  = step_ms(touch_timing_config[`TCTC_RPT_MSB:`TCTC_RPT_LSB]);
  // RULE12 hold decode
  assign limit_hold = step_ms(hold_threshold_config[`TCTC_HOLD_MSB:`TCTC_HOLD_LSB]);

  tctc_pkg::tctc_ms_type dur      [CHANNELS];
  tctc_pkg::tctc_ms_type rpt      [CHANNELS];
  tctc_pkg::tctc_ms_type next_dur [CHANNELS];
  tctc_pkg::tctc_ms_type next_rpt [CHANNELS];
  logic [CHANNELS-1:0]   held;
  logic [CHANNELS-1:0]   recal_done;
  logic [CHANNELS-1:0]   next_held;
  logic [CHANNELS-1:0]   next_recal_done;
  logic [CHANNELS-1:0]   active;
  logic [CHANNELS-1:0]   rise;
  logic [CHANNELS-1:0]   fall;
  logic [CHANNELS-1:0]   hold_ev;
  logic [CHANNELS-1:0]   rpt_ev;
  logic [CHANNELS-1:0]   recal_ev;

  // RULE1 gate by enable
  assign active = touch_sync & channel_sample_enable[CHANNELS-1:0];
  assign rise   = active & ~touch_detected;
  assign fall   = touch_detected & channel_sample_enable[CHANNELS-1:0] & ~touch_sync;

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      // RULE13 clear when idle
      next_dur[i] = '0;
      next_rpt[i] = '0;
      hold_ev[i]  = 1'b0;
      rpt_ev[i]   = 1'b0;
      recal_ev[i] = 1'b0;
      if (active[i]) begin
        next_dur[i] = dur[i];
        next_rpt[i] = rpt[i];
        if (tick && dur[i] != `TCTC_DUR_SAT) begin
          next_dur[i] = dur[i] + 14'h0001;
        end
        // RULE11 longer than threshold
        hold_ev[i] = tick && auto_repeat_en[i] && !held[i] && dur[i] == limit_hold;
        // RULE6 gated recalibration
        recal_ev[i] = tick && max_touch_recal_en && !recal_done[i] &&
                      next_dur[i] == limit_max;
        if (held[i] && tick) begin
          rpt_ev[i]   = rpt[i] == limit_rpt - 14'h0001;
          next_rpt[i] = rpt_ev[i] ? 14'h0000 : rpt[i] + 14'h0001;
        end
      end
    end
  end

  assign next_held       = active & (held | hold_ev);
  assign next_recal_done = active & (recal_done | recal_ev);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dur            <= '{default: '0};
      rpt            <= '{default: '0};
      held           <= '0;
      recal_done     <= '0;
      touch_detected <= '0;
      sample_en      <= '0;
      recal_req      <= '0;
      hold_event     <= '0;
      touch_event    <= '0;
      irq_req        <= 1'b0;
    end else begin
      dur            <= next_dur;
      rpt            <= next_rpt;
      held           <= next_held;
      recal_done     <= next_recal_done;
      touch_detected <= active;
      sample_en      <= channel_sample_enable[CHANNELS-1:0];
      recal_req      <= recal_ev;
      hold_event     <= hold_ev;
      // RULE11 short touch event
      touch_event    <= fall & auto_repeat_en & ~held;
      // RULE9 press repeat release
      irq_req        <= |(rise | rpt_ev | (fall & {CHANNELS{~release_irq_suppress}}));
    end
  end

endmodule // tctc_top

// ### tb/tctc_top_asserts.sv
`timescale 1ns/1ps
module tctc_top_asserts #(
  parameter int TICK_CYCLES = 125000,
  parameter int CHANNELS    = 8
) (
  input wire logic                clk,
  input wire logic                sys_rst,
  input wire logic [7:0]          reg_addr,
  input wire logic                reg_wr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata,
  input wire logic [CHANNELS-1:0] touch_raw,
  input wire logic [CHANNELS-1:0] auto_repeat_en,
  input wire logic                max_touch_recal_en,
  input wire logic                release_irq_suppress,
  input wire logic [CHANNELS-1:0] sample_en,
  input wire logic                cycle_start,
  input wire logic [CHANNELS-1:0] touch_detected,
  input wire logic [CHANNELS-1:0] recal_req,
  input wire logic [CHANNELS-1:0] hold_event,
  input wire logic [CHANNELS-1:0] touch_event,
  input wire logic                irq_req
);
  int   gap;
  logic seen;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Cycles since last cycle start
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap  <= 0;
      seen <= 1'b0;
    end else begin
      gap  <= cycle_start ? 1 : gap + 1;
      seen <= seen | cycle_start;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_wen; reg_wr && reg_addr == 8'h21 |=> ##1 sample_en == $past(reg_wdata, 2); endproperty
  a_wen: assert property (p_wen) else $error("enable copy wrong");
  property p_hold; reg_rd && reg_addr == 8'h23 |=> reg_rdata[7:4] == 4'h0; endproperty
  a_hold: assert property (p_hold) else $error("unused bits read");
  property p_cyc; cycle_start && seen |-> gap == 70 * TICK_CYCLES; endproperty
  a_cyc: assert property (p_cyc) else $error("cycle length wrong");
  property p_irq; (touch_detected & ~$past(touch_detected)) != 0 |-> irq_req; endproperty
  a_irq: assert property (p_irq) else $error("no press irq");
  property p_auto; ((hold_event | touch_event) & ~$past(auto_repeat_en)) == 0; endproperty
  a_auto: assert property (p_auto) else $error("event on plain input");
  property p_recal; recal_req != 0 |-> $past(max_touch_recal_en); endproperty
  a_recal: assert property (p_recal) else $error("recal while off");
  property p_tdet; (touch_detected & ~(sample_en & $past(touch_raw, 3))) == 0; endproperty
  a_tdet: assert property (p_tdet) else $error("disabled input seen");
  property p_hpl; hold_event != 0 |=> hold_event == 0; endproperty
  a_hpl: assert property (p_hpl) else $error("hold pulse long");
endmodule // tctc_top_asserts
bind tctc_top tctc_top_asserts #(.TICK_CYCLES(TICK_CYCLES), .CHANNELS(CHANNELS)) u_chk (.*);

// ### tb/tctc_host.sv
`timescale 1ns/1ps
module tctc_host (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // After a write, idle address and data show inverted values; a read inverts only the address
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask
endmodule // tctc_host

// ### tb/touch_channel_timing_control_bench.sv
`timescale 1ns/1ps
module touch_channel_timing_control_bench;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       reg_wr, reg_rd, cycle_start, irq_req;
  logic       max_touch_recal_en = 1'b0;
  logic       release_irq_suppress = 1'b0;
  logic       clr = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, sample_en, touch_detected;
  logic [7:0] recal_req, hold_event, touch_event;
  logic [7:0] touch_raw = 8'h00;
  logic [7:0] auto_repeat_en = 8'hff;
  logic [7:0] tv [3] = '{8'h01, 8'h01, 8'h11};
  logic       ev [3] = '{1'b1, 1'b0, 1'b1};
  int         ex [3] = '{1, 0, 0};
  int         num_errors, n_checks, n_irq, n_hold, n_tev, n_rec, cyc, t_det, t_hold, t_irq, gap;
  tctc_top #(.TICK_CYCLES(4)) dut (.*);
  tctc_host host (.*);
  initial forever #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  // Event counters, timestamps and run limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_irq <= clr ? 0 : n_irq + int'(irq_req);
    n_hold <= clr ? 0 : n_hold + int'(hold_event != 0);
    n_tev <= clr ? 0 : n_tev + int'(touch_event != 0);
    n_rec <= clr ? 0 : n_rec + int'(recal_req != 0);
    if ($rose(touch_detected[0])) t_det <= cyc;
    if (hold_event[0]) t_hold <= cyc;
    if (irq_req) begin
      gap <= cyc - t_irq;
      t_irq <= cyc;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic checkn(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("ERROR %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    check8(d, e);
  endtask
  task automatic press(input logic [7:0] m, input int n);
    @(negedge clk);
    clr       = 1'b1;
    touch_raw = m;
    @(negedge clk);
    clr       = 1'b0;
    repeat (n - 1) @(negedge clk);
    touch_raw = 8'h00;
    repeat (20) @(negedge clk);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    fork
      begin
        wait (cyc > 40000);
        $display("ERROR %0t timeout", $time);
        num_errors++;
        finish_test();
      end
    join_none
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    rchk(8'h21, 8'hff);
    rchk(8'h22, 8'ha4);
    rchk(8'h23, 8'h07);
    rchk(8'h24, 8'h00);
    host.wr(8'h23, 8'hf1);
    rchk(8'h23, 8'h01);
    host.wr(8'h22, 8'h01);
    rchk(8'h22, 8'h01);
    $display("test registers done");
    press(8'h80, 100);
    checkn(n_irq, 2, 2);
    checkn(n_tev, 1, 1);
    checkn(n_hold, 0, 0);
    release_irq_suppress = 1'b1;
    press(8'h01, 1400);
    checkn(t_hold - t_det, 276, 292);
    checkn(gap, 280, 280);
    checkn(n_tev + n_rec, 0, 0);
    $display("test hold done");
    for (int i = 0; i < 3; i++) begin
      host.wr(8'h22, tv[i]);
      max_touch_recal_en = ev[i];
      press(8'h02, 2800);
      checkn(n_rec, ex[i], ex[i]);
    end
    $display("test recal done");
    host.wr(8'h21, 8'hfe);
    repeat (3) @(negedge clk);
    check8(sample_en, 8'hfe);
    press(8'h01, 100);
    checkn(n_irq, 0, 0);
    host.wr(8'h21, 8'hff);
    touch_raw = 8'h01;
    repeat (200) @(negedge clk);
    host.wr(8'h21, 8'hfe);
    repeat (20) @(negedge clk);
    host.wr(8'h21, 8'hff);
    press(8'h01, 200);
    checkn(n_hold, 0, 0);
    auto_repeat_en = 8'hfe;
    press(8'h01, 400);
    checkn(n_hold + n_tev, 0, 0);
    checkn(n_irq, 1, 1);
    $display("test disable done");
    finish_test();
  end
endmodule // touch_channel_timing_control_bench
